// ==== logic/nvpl_core.v ====
// The register offsets and the Avalon-MM register port are this design's own decisions.
`timescale 1ns/10ps
`include "nvpl_consts.vh"

module nvpl_core #(
   parameter NUM_IRQ = `NVPL_NUM_IRQ
) (
   // Clock and reset
   input  wire                     ref_clk,
   input  wire                     rst,
   // Avalon-MM slave
   input  wire [`NVPL_ADDR_W-1:0]  avs_address,
   input  wire                     avs_read,
   input  wire                     avs_write,
   input  wire [31:0]              avs_writedata,
   output reg  [31:0]              avs_readdata,
   output reg                      avs_waitrequest,
   // Request pins from peripherals
   input  wire [NUM_IRQ-1:0]       irq_pin,
   input  wire                     nmi_pin,
   // Core exception entry and return
   input  wire                     core_entry,
   input  wire [`NVPL_ID_W-1:0]    core_entry_id,
   input  wire                     core_return,
   input  wire [`NVPL_ID_W-1:0]    core_return_id,
   // Selected request and NMI request towards the core
   output reg                      svc_valid,
   output reg  [`NVPL_ID_W-1:0]    svc_id,
   output reg  [`NVPL_PRIO_W-1:0]  svc_group,
   output reg  [`NVPL_PRIO_W-1:0]  svc_sub,
   output reg                      nmi_req,
   // Interrupt to software
   output reg                      irq_out
);

   // Pin synchronisers and filtered levels
   reg  [NUM_IRQ-1:0]           sync1_reg;
   reg  [NUM_IRQ-1:0]           sync2_reg;
   reg  [NUM_IRQ-1:0]           sync3_reg;
   reg  [NUM_IRQ-1:0]           line_reg;
   reg  [NUM_IRQ-1:0]           line_d_reg;
   reg  [2:0]                   nmi_sync_reg;
   reg                          nmi_line_reg;
   reg                          nmi_line_d_reg;

   // Interrupt state and configuration
   reg  [NUM_IRQ-1:0]           pend_reg;
   reg  [NUM_IRQ-1:0]           act_reg;
   reg  [NUM_IRQ-1:0]           enable_reg;
   reg  [NUM_IRQ-1:0]           pulse_reg;
   reg  [`NVPL_SPLIT_W-1:0]     split_reg;
   reg  [`NVPL_STAT_W-1:0]      status_reg;
   reg  [`NVPL_STAT_W-1:0]      mask_reg;
   reg  [`NVPL_PRIO_W-1:0]      prio_reg [0:NUM_IRQ-1];

   wire [NUM_IRQ-1:0]           pend_next;
   wire [NUM_IRQ-1:0]           act_next;
   wire [NUM_IRQ-1:0]           rise;
   wire [NUM_IRQ-1:0]           wr_prio;
   wire [`NVPL_STAT_W-1:0]      status_next;

   // Bus decode
   wire                         wr_go;
   wire                         rd_go;
   reg  [31:0]                  rdata;
   integer                      k;

   // Selection
   reg                          sel_found;
   reg  [`NVPL_ID_W-1:0]        sel_id;
   reg  [`NVPL_PRIO_W-1:0]      sel_prio;
   reg  [`NVPL_PRIO_W-1:0]      sub_mask;
   integer                      j;

   assign wr_go = avs_write & ~avs_waitrequest;
   assign rd_go = avs_read & avs_waitrequest;
   assign rise  = line_reg & ~line_d_reg;

   // Three-stage sampling; a change is taken when stages two and three agree
   always @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         sync1_reg      <= {NUM_IRQ{1'b0}};
         sync2_reg      <= {NUM_IRQ{1'b0}};
         sync3_reg      <= {NUM_IRQ{1'b0}};
         line_reg       <= {NUM_IRQ{1'b0}};
         line_d_reg     <= {NUM_IRQ{1'b0}};
         nmi_sync_reg   <= 3'h0;
         nmi_line_reg   <= 1'b0;
         nmi_line_d_reg <= 1'b0;
      end else begin
         sync1_reg  <= irq_pin;
         sync2_reg  <= sync1_reg;
         sync3_reg  <= sync2_reg;
         line_reg   <= (sync2_reg & sync3_reg) |
                       (line_reg & (sync2_reg | sync3_reg));
         line_d_reg <= line_reg;
         nmi_sync_reg <= {nmi_sync_reg[1:0], nmi_pin};
         nmi_line_reg <= (nmi_sync_reg[1] & nmi_sync_reg[2]) |
                         (nmi_line_reg &
                          (nmi_sync_reg[1] | nmi_sync_reg[2]));
         nmi_line_d_reg <= nmi_line_reg;
      end
   end

   // Per-interrupt state machine: pending and active bits
   genvar g;
   generate
      for (g = 0; g < NUM_IRQ; g = g + 1) begin : gen_irq
         wire ent;
         wire ret;
         wire hw_set;
         wire sw_set;
         wire clr;
         reg  p;
         reg  a;
         localparam [`NVPL_ID_W-1:0] IDX   = g;
         localparam [7:0]            PADDR = `NVPL_OFS_PRIO + 4 * g;

         assign ent = core_entry & (core_entry_id == IDX);
         assign ret = core_return & (core_return_id == IDX);
         // Pulse mode latches an edge; level mode pends while idle
         // Entry masks the level term so a held line cannot block
         assign hw_set = pulse_reg[g] ? rise[g]
                         : (line_reg[g] & ~act_reg[g] & ~ent);
         assign sw_set = wr_go &
            (((avs_address == `NVPL_OFS_SETPEND) &&
              avs_writedata[g]) ||
             ((avs_address == `NVPL_OFS_SOFTWARE_TRIGGER_REG) &&
              (avs_writedata[`NVPL_ID_W-1:0] == IDX)));
         assign clr = wr_go && (avs_address == `NVPL_OFS_CLRPEND) &&
                      avs_writedata[g];

         always @* begin
            p = pend_reg[g];
            a = act_reg[g];
            if (clr) begin
               if (pulse_reg[g])
                  p = 1'b0;
               else if (!line_reg[g])
                  p = 1'b0;
            end
            if (ret) begin
               a = 1'b0;
               if (!pulse_reg[g])
                  p = line_reg[g];
            end
            if (ent) begin
               p = 1'b0;
               a = 1'b1;
            end
            // A new request wins over a clear in the same cycle
            if (hw_set || sw_set)
               p = 1'b1;
         end

         assign pend_next[g] = p;
         assign act_next[g]  = a;
         assign wr_prio[g] = wr_go && (avs_address == PADDR);
         assign status_next[g] = (status_reg[g] &
            ~(wr_go && (avs_address == `NVPL_OFS_STATUS) &&
              avs_writedata[g])) | (p & ~pend_reg[g]);

         always @(posedge ref_clk or posedge rst) begin
            if (rst)
               prio_reg[g] <= {`NVPL_PRIO_W{1'b0}};
            else if (wr_prio[g])
               prio_reg[g] <= avs_writedata[`NVPL_PRIO_W-1:0];
         end
      end
   endgenerate

   // NMI edge event, set wins over the clear
   assign status_next[`NVPL_NMI_BIT] = (status_reg[`NVPL_NMI_BIT] &
      ~(wr_go && (avs_address == `NVPL_OFS_STATUS) &&
        avs_writedata[`NVPL_NMI_BIT])) |
      (nmi_line_reg & ~nmi_line_d_reg);

   // Most urgent pending enabled request, lowest number on ties
   always @* begin
      sel_found = 1'b0;
      sel_id    = {`NVPL_ID_W{1'b0}};
      sel_prio  = {`NVPL_PRIO_W{1'b1}};
      for (j = NUM_IRQ - 1; j >= 0; j = j - 1) begin
         if (pend_reg[j] && enable_reg[j] && !act_reg[j] &&
             (!sel_found || prio_reg[j] <= sel_prio)) begin
            sel_found = 1'b1;
            sel_id    = j[`NVPL_ID_W-1:0];
            sel_prio  = prio_reg[j];
         end
      end
      sub_mask = ~({`NVPL_PRIO_W{1'b1}} << split_reg);
   end

   // Register read mux
   always @* begin
      rdata    = 32'h0;
      case (avs_address)
         `NVPL_OFS_ENABLE:  rdata[NUM_IRQ-1:0] = enable_reg;
         `NVPL_OFS_SETPEND: rdata[NUM_IRQ-1:0] = pend_reg;
         `NVPL_OFS_CLRPEND: rdata[NUM_IRQ-1:0] = pend_reg;
         `NVPL_OFS_ACTIVE:  rdata[NUM_IRQ-1:0] = act_reg;
         `NVPL_OFS_PULSE:   rdata[NUM_IRQ-1:0] = pulse_reg;
         `NVPL_OFS_SPLIT:   rdata[`NVPL_SPLIT_W-1:0] = split_reg;
         `NVPL_OFS_STATUS:  rdata[`NVPL_STAT_W-1:0] = status_reg;
         `NVPL_OFS_MASK:    rdata[`NVPL_STAT_W-1:0] = mask_reg;
         `NVPL_OFS_SELECT: begin
            rdata[`NVPL_ID_W-1:0] = sel_id;
            rdata[10:8]           = sel_prio;
            rdata[16]             = sel_found;
            rdata[17]             = nmi_line_reg;
         end
         default: begin
            for (k = 0; k < NUM_IRQ; k = k + 1) begin
               if (avs_address == (`NVPL_OFS_PRIO + 4 * k))
                  rdata[`NVPL_PRIO_W-1:0] = prio_reg[k];
            end
         end
      endcase
   end

   // Bus handshake: one wait cycle, then the access completes
   always @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         avs_waitrequest <= 1'b1;
         avs_readdata    <= 32'h0;
      end else begin
         if ((avs_read || avs_write) && avs_waitrequest)
            avs_waitrequest <= 1'b0;
         else
            avs_waitrequest <= 1'b1;
         if (rd_go)
            avs_readdata <= rdata;
      end
   end

   // Configuration and state registers
   always @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         pend_reg   <= {NUM_IRQ{1'b0}};
         act_reg    <= {NUM_IRQ{1'b0}};
         enable_reg <= {NUM_IRQ{1'b0}};
         pulse_reg  <= {NUM_IRQ{1'b0}};
         split_reg  <= {`NVPL_SPLIT_W{1'b0}};
         status_reg <= {`NVPL_STAT_W{1'b0}};
         mask_reg   <= {`NVPL_STAT_W{1'b0}};
      end else begin
         pend_reg   <= pend_next;
         act_reg    <= act_next;
         status_reg <= status_next;
         if (wr_go) begin
            case (avs_address)
               `NVPL_OFS_ENABLE:
                  enable_reg <= avs_writedata[NUM_IRQ-1:0];
               `NVPL_OFS_PULSE:
                  pulse_reg <= avs_writedata[NUM_IRQ-1:0];
               `NVPL_OFS_SPLIT:
                  split_reg <= avs_writedata[`NVPL_SPLIT_W-1:0];
               `NVPL_OFS_MASK:
                  mask_reg <= avs_writedata[`NVPL_STAT_W-1:0];
               default: ;
            endcase
         end
      end
   end

   // Registered outputs towards the core and software
   always @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         svc_valid <= 1'b0;
         svc_id    <= {`NVPL_ID_W{1'b0}};
         svc_group <= {`NVPL_PRIO_W{1'b0}};
         svc_sub   <= {`NVPL_PRIO_W{1'b0}};
         nmi_req   <= 1'b0;
         irq_out   <= 1'b0;
      end else begin
         svc_valid <= sel_found;
         svc_id    <= sel_id;
         svc_group <= sel_prio >> split_reg;
         svc_sub   <= sel_prio & sub_mask;
         nmi_req   <= nmi_line_reg;
         irq_out   <= |(status_reg & mask_reg);
      end
   end

endmodule // nvpl_core

// ==== logic/nvpl_consts.vh ====
`ifndef NVPL_CONSTS_VH
`define NVPL_CONSTS_VH

`define NVPL_NUM_IRQ     26
`define NVPL_PRIO_W      3
`define NVPL_ID_W        5
`define NVPL_ADDR_W      8

`define NVPL_OFS_ENABLE  8'h00
`define NVPL_OFS_SETPEND 8'h04
`define NVPL_OFS_CLRPEND 8'h08
`define NVPL_OFS_ACTIVE  8'h0c
`define NVPL_OFS_PULSE   8'h10
`define NVPL_OFS_SOFTWARE_TRIGGER_REG  8'h14
`define NVPL_OFS_SPLIT   8'h18
`define NVPL_OFS_STATUS  8'h1c
`define NVPL_OFS_MASK    8'h20
`define NVPL_OFS_SELECT  8'h24
`define NVPL_OFS_PRIO    8'h40

`define NVPL_NMI_BIT     26
`define NVPL_STAT_W      27
`define NVPL_SPLIT_W     2

`endif

// ==== testbench/nvpl_checker.sv ====
`timescale 1ns/10ps
`include "nvpl_consts.vh"
module nvpl_checker #(
   parameter NUM_IRQ = 26
) (
   // Clock and reset
   input wire                  ref_clk,
   input wire                  rst,
   // Register bus
   input wire                  avs_read,
   input wire                  avs_write,
   input wire [31:0]           avs_readdata,
   input wire                  avs_waitrequest,
   // Requests and selection
   input wire                  nmi_pin,
   input wire                  core_entry,
   input wire [`NVPL_ID_W-1:0] core_entry_id,
   input wire                  svc_valid,
   input wire [`NVPL_ID_W-1:0] svc_id,
   input wire                  nmi_req
);
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (rst);
   sequence s_req;
      (avs_read || avs_write) && avs_waitrequest;
   endsequence
   sequence s_nmi_up;
      $rose(nmi_pin) ##1 nmi_pin [*5];
   endsequence
   sequence s_nmi_dn;
      $fell(nmi_pin) ##1 !nmi_pin [*5];
   endsequence
   property p_ans;
      s_req |=> !avs_waitrequest;
   endproperty
   a_ans: assert property (p_ans) else $error("no bus answer");
   property p_one;
      !avs_waitrequest |=> avs_waitrequest;
   endproperty
   a_one: assert property (p_one) else $error("long answer");
   property p_cause;
      !avs_waitrequest |-> $past(avs_read || avs_write);
   endproperty
   a_cause: assert property (p_cause) else $error("stray answer");
   property p_hold;
      !avs_read |=> $stable(avs_readdata);
   endproperty
   a_hold: assert property (p_hold) else $error("read data moved");
   property p_nmi_on;
      s_nmi_up |-> nmi_req;
   endproperty
   a_nmi_on: assert property (p_nmi_on) else $error("nmi missed");
   property p_nmi_off;
      s_nmi_dn |-> !nmi_req;
   endproperty
   a_nmi_off: assert property (p_nmi_off) else $error("nmi stuck");
   property p_entry;
      core_entry |-> ##2 !(svc_valid && svc_id == $past(core_entry_id, 2));
   endproperty
   a_entry: assert property (p_entry) else $error("active reselected");
   property p_drop;
      $fell(svc_valid) |-> $past(core_entry, 2) || $past(avs_write, 2);
   endproperty
   a_drop: assert property (p_drop) else $error("pending lost");
endmodule // nvpl_checker

bind nvpl_core nvpl_checker #(.NUM_IRQ(NUM_IRQ)) u_chk (
   .ref_clk(ref_clk), .rst(rst), .avs_read(avs_read),
   .avs_write(avs_write), .avs_readdata(avs_readdata),
   .avs_waitrequest(avs_waitrequest), .nmi_pin(nmi_pin),
   .core_entry(core_entry), .core_entry_id(core_entry_id),
   .svc_valid(svc_valid), .svc_id(svc_id), .nmi_req(nmi_req));

// ==== testbench/nvpl_far_end.sv ====
`timescale 1ns/10ps
module nvpl_far_end (
   // Clock
   input  wire              ref_clk,
   // Peripheral request lines
   output logic [25:0]      irq_pin,
   output logic             nmi_pin,
   // Core exception entry and return
   output logic             core_entry,
   output logic [4:0]       core_entry_id,
   output logic             core_return,
   output logic [4:0]       core_return_id
);
   initial begin
      {irq_pin, nmi_pin, core_entry, core_return} = '0;
      {core_entry_id, core_return_id} = '0;
   end
   task pulse(input int i);
      @(posedge ref_clk);
      irq_pin[i] <= 1'b1;
      repeat (2) @(posedge ref_clk);
      irq_pin[i] <= 1'b0;
   endtask
   task nmi(input logic v);
      @(posedge ref_clk);
      nmi_pin <= v;
   endtask
   task line(input int i, input logic v);
      @(posedge ref_clk);
      irq_pin[i] <= v;
   endtask
   task core(input logic ret, input logic [4:0] id, input int lag);
      repeat (lag + 1) @(posedge ref_clk);
      core_entry     <= !ret;
      core_return    <= ret;
      core_entry_id  <= id;
      core_return_id <= id;
      @(posedge ref_clk);
      {core_entry, core_return} <= 2'b00;
      core_entry_id  <= ~id;
      core_return_id <= ~id;
   endtask
endmodule // nvpl_far_end

// ==== testbench/nested_interrupt_pending_logic_bench.sv ====
`timescale 1ns/10ps
module nested_interrupt_pending_logic_bench;
   logic ref_clk, rst, avs_read, avs_write, avs_waitrequest, nmi_pin;
   logic core_entry, core_return, svc_valid, nmi_req, irq_out;
   logic [7:0] avs_address;
   logic [31:0] avs_writedata, avs_readdata, q;
   logic [25:0] irq_pin;
   logic [4:0] core_entry_id, core_return_id, svc_id;
   logic [2:0] svc_group, svc_sub;
   int bad_count, tests_run;
   nvpl_core u_dut (.ref_clk(ref_clk), .rst(rst), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write),
      .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .irq_pin(irq_pin),
      .nmi_pin(nmi_pin), .core_entry(core_entry),
      .core_entry_id(core_entry_id), .core_return(core_return),
      .core_return_id(core_return_id), .svc_valid(svc_valid),
      .svc_id(svc_id), .svc_group(svc_group), .svc_sub(svc_sub),
      .nmi_req(nmi_req), .irq_out(irq_out));
   nvpl_far_end u_far (.ref_clk(ref_clk), .irq_pin(irq_pin),
      .nmi_pin(nmi_pin), .core_entry(core_entry),
      .core_entry_id(core_entry_id), .core_return(core_return),
      .core_return_id(core_return_id));
   initial begin
      ref_clk = 1'b0;
      forever #2.5 ref_clk = ~ref_clk;
   end
   task summarize;
      $display("checks %0d mismatches %0d", tests_run, bad_count);
      if (bad_count == 0 && tests_run > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   task chk(input logic [31:0] g, input logic [31:0] e, input string m);
      tests_run++;
      if (g !== e) begin
         bad_count++;
         $display("BAD %0t %s got %h exp %h", $time, m, g, e);
      end
   endtask
   // One Avalon access; waits for waitrequest low under a bound
   task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge ref_clk);
      avs_address   <= a;
      avs_writedata <= d;
      avs_write     <= w;
      avs_read      <= !w;
      do begin
         @(posedge ref_clk);
         n++;
      end while (avs_waitrequest !== 1'b0 && n < 20);
      q = avs_readdata;
      avs_write <= 1'b0;
      avs_read  <= 1'b0;
      if (n >= 20) chk(1'b0, 1'b1, "bus hang");
   endtask
   task ck(input logic [7:0] a, input logic [31:0] e);
      bus(1'b0, a, 32'h0);
      chk(q, e, "register");
   endtask
   task pause;
      repeat (8) @(posedge ref_clk);
   endtask
   task t_regs;
      ck(8'h00, 32'h0);
      ck(8'ha4, 32'h0);
      bus(1'b1, 8'h30, 32'hffffffff);
      ck(8'h30, 32'h0);
      bus(1'b1, 8'h00, 32'hffffffff);
      ck(8'h00, 32'h03ffffff);
      bus(1'b1, 8'h44, 32'hffffffff);
      ck(8'h44, 32'h7);
   endtask
   task t_prio;
      bus(1'b1, 8'h5c, 32'h5);
      bus(1'b1, 8'h64, 32'h2);
      bus(1'b1, 8'h48, 32'h2);
      bus(1'b1, 8'h14, 32'h7);
      bus(1'b1, 8'h04, 32'h204);
      bus(1'b1, 8'h18, 32'h1);
      ck(8'h04, 32'h284);
      chk(32'(svc_id), 32'd2, "tie");
      chk({svc_group, svc_sub}, 6'o10, "split");
      bus(1'b1, 8'h64, 32'h0);
      pause;
      chk(32'(svc_id), 32'd9, "reprio");
      bus(1'b1, 8'h08, 32'h284);
      ck(8'h04, 32'h0);
   endtask
   task t_pulse;
      bus(1'b1, 8'h10, 32'h8);
      u_far.pulse(3);
      pause;
      ck(8'h04, 32'h8);
      chk(32'(svc_id), 32'd3, "pick");
      u_far.core(1'b0, 5'd3, 0);
      u_far.pulse(3);
      pause;
      ck(8'h0c, 32'h8);
      ck(8'h04, 32'h8);
      bus(1'b1, 8'h08, 32'h8);
      ck(8'h04, 32'h0);
      ck(8'h0c, 32'h8);
      u_far.pulse(3);
      pause;
      u_far.core(1'b1, 5'd3, 0);
      ck(8'h04, 32'h8);
      u_far.core(1'b0, 5'd3, 3);
      u_far.core(1'b1, 5'd3, 0);
      ck(8'h04, 32'h0);
      ck(8'h0c, 32'h0);
   endtask
   task t_level;
      u_far.line(5, 1'b1);
      pause;
      ck(8'h04, 32'h20);
      bus(1'b1, 8'h08, 32'h20);
      ck(8'h04, 32'h20);
      u_far.core(1'b0, 5'd5, 0);
      ck(8'h04, 32'h0);
      u_far.core(1'b1, 5'd5, 0);
      pause;
      ck(8'h04, 32'h20);
      u_far.line(5, 1'b0);
      u_far.core(1'b0, 5'd5, 8);
      u_far.core(1'b1, 5'd5, 0);
      ck(8'h04, 32'h0);
   endtask
   task t_irq;
      bus(1'b1, 8'h1c, 32'hffffffff);
      bus(1'b1, 8'h20, 32'h04000000);
      chk(32'(irq_out), 32'h0, "quiet");
      u_far.nmi(1'b1);
      pause;
      chk(32'(nmi_req), 32'h1, "nmi");
      chk(32'(irq_out), 32'h1, "raise");
      bus(1'b1, 8'h20, 32'h0);
      pause;
      chk(32'(irq_out), 32'h0, "masked");
      bus(1'b1, 8'h20, 32'h04000000);
      bus(1'b1, 8'h1c, 32'h04000000);
      pause;
      chk(32'(irq_out), 32'h0, "cleared");
      u_far.nmi(1'b0);
      pause;
      chk(32'(nmi_req), 32'h0, "nmi low");
   endtask
   initial begin
      {rst, avs_read, avs_write, avs_address, avs_writedata} = '0;
      {bad_count, tests_run} = '0;
      rst = 1'b1;
      repeat (16) @(posedge ref_clk);
      rst <= 1'b0;
      t_regs;
      t_prio;
      t_pulse;
      t_level;
      t_irq;
      summarize;
   end
   initial begin
      repeat (20000) @(posedge ref_clk);
      bad_count++;
      summarize;
   end
endmodule // nested_interrupt_pending_logic_bench
